/* File: core/dmr_pkg.sv */
package dmr_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 100;        // 10 MHz
  localparam int unsigned PULSE_SHORT_NS = 2_200_000;  // 2.2 ms
  localparam int unsigned PULSE_LONG_NS  = 70_000_000; // 70 ms
  localparam int unsigned HOLD_LOW_NS    = 50_000_000; // plain default

  // least times round up to whole cycles
  localparam int unsigned PULSE_SHORT_CYC =
    (PULSE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_LONG_CYC  =
    (PULSE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_LOW_CYC    =
    (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int unsigned CNT_W        = 21;
  localparam logic [1:0]  SYNC_RST_VAL = 2'h3;  // inputs idle high
  localparam logic        OUT_RST_VAL  = 1'h1;  // output at rest

  // ***************************************************************
  // sequencer states, gray along idle-hold-pulse-spent
  // ***************************************************************
  typedef enum logic [1:0] {
    DMR_IDLE  = 2'h0,
    DMR_HOLD  = 2'h1,
    DMR_PULSE = 2'h3,
    DMR_SPENT = 2'h2
  } dmr_state_t;

endpackage

/* File: core/dmr_sync.sv */
`timescale 1ns/100ps

// ***************************************************************
// two-stage synchroniser for the two manual reset pins
// ***************************************************************
module dmr_sync
  import dmr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] pin_n,
  output logic      [1:0] sync_n
);

  logic [1:0] meta;
  logic [1:0] next_meta;
  logic [1:0] next_sync_n;

  // first stage feeds only the second stage
  always_comb begin
    next_meta   = pin_n;
    next_sync_n = meta;
  end

  // reset to inactive high, as an undriven second pin would read
  always_ff @(posedge clk) begin
    if (rst) begin
      meta   <= SYNC_RST_VAL;
      sync_n <= SYNC_RST_VAL;
    end else begin
      meta   <= next_meta;
      sync_n <= next_sync_n;
    end
  end

endmodule

/* File: core/dmr_timer.sv */
`timescale 1ns/100ps

module dmr_timer
  import dmr_pkg::*;
#(
  parameter bit          LONG_VARIANT    = 1'b0,
  parameter int unsigned HOLD_CYC        = HOLD_LOW_CYC,
  parameter int unsigned PULSE_SHORT_LEN = PULSE_SHORT_CYC,
  parameter int unsigned PULSE_LONG_LEN  = PULSE_LONG_CYC
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic first_manual_reset_input_n,
  input  wire logic second_manual_reset_input_n,
  output logic      sys_reset_n
);

  // ***************************************************************
  // derived lengths
  // ***************************************************************
  localparam int unsigned PULSE_CYC =
    LONG_VARIANT ? PULSE_LONG_LEN : PULSE_SHORT_LEN;
  localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);

  // ***************************************************************
  // input synchronisation and edge detection
  // ***************************************************************
  logic [1:0] in_n;
  logic [1:0] prev_n;
  logic [1:0] next_prev_n;
  logic       both_low;
  logic       any_fall;

  dmr_sync u_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_n  ({second_manual_reset_input_n, first_manual_reset_input_n}),
    .sync_n (in_n)
  );

  // edges taken from the synchronised copy only
  always_comb begin
    next_prev_n = in_n;
    both_low    = (in_n == 2'h0);
    any_fall    = |(prev_n & ~in_n);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_n <= SYNC_RST_VAL;
    end else begin
      prev_n <= next_prev_n;
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  dmr_state_t       state;
  dmr_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             rearm;
  logic             next_rearm;
  logic             next_sys_reset_n;

  // one counter serves hold and pulse; they never overlap
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_rearm = rearm;
    unique case (state)
      DMR_IDLE: begin
        next_cnt = '0;
        if (both_low) begin
          next_state = DMR_HOLD;
        end
      end
      DMR_HOLD: begin
        if (!both_low) begin
          next_state = DMR_IDLE;
          next_cnt   = '0;
        end else if (cnt == HOLD_LAST) begin
          next_state = DMR_PULSE;
          next_cnt   = '0;
          next_rearm = 1'b0;
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      DMR_PULSE: begin
        // pulse width is fixed, an edge only arms a fresh hold
        if (any_fall) begin
          next_rearm = 1'b1;
        end
        if (cnt == PULSE_LAST) begin
          next_cnt = '0;
          if (both_low && !(rearm || any_fall)) begin
            next_state = DMR_SPENT;
          end else begin
            next_state = DMR_IDLE;
          end
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      DMR_SPENT: begin
        next_cnt = '0;
        // a release is needed before any new hold
        if (!both_low) begin
          next_state = DMR_IDLE;
        end
      end
    endcase
    next_sys_reset_n = (next_state != DMR_PULSE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= DMR_IDLE;
      cnt         <= '0;
      rearm       <= 1'b0;
      sys_reset_n <= OUT_RST_VAL;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      rearm       <= next_rearm;
      sys_reset_n <= next_sys_reset_n;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [CNT_W-1:0] low_run;
  logic [CNT_W-1:0] pulse_len;
  logic [CNT_W-1:0] next_low_run;
  logic [CNT_W-1:0] next_pulse_len;

  // helper counts: consecutive low cycles since the last release, and
  // cycles spent with the output low; the run count saturates so a very
  // long hold cannot wrap it back under the timeout
  always_comb begin
    next_low_run   = low_run;
    next_pulse_len = '0;
    if (!both_low) begin
      next_low_run = '0;
    end else if (low_run != {CNT_W{1'b1}}) begin
      next_low_run = low_run + CNT_W'(1);
    end
    if (!sys_reset_n) begin
      next_pulse_len = pulse_len + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_run   <= '0;
      pulse_len <= '0;
    end else begin
      low_run   <= next_low_run;
      pulse_len <= next_pulse_len;
    end
  end

  default clocking dmr_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_PULSE_NEEDS_HOLD: assert property (
    $fell(sys_reset_n) |->
      $past(both_low) && ($past(low_run) >= CNT_W'(HOLD_CYC))
  ) else $error("reset pulse began without a full low hold");

  AST_PULSE_WIDTH: assert property (
    $rose(sys_reset_n) |-> (pulse_len == CNT_W'(PULSE_CYC))
  ) else $error("reset pulse width wrong");

  AST_CLEAR_ON_RELEASE: assert property (
    (state == DMR_HOLD && !both_low) |=>
      (state == DMR_IDLE) && (cnt == '0) && sys_reset_n
  ) else $error("hold timer not cleared on release");

  AST_LATER_START: assert property (
    (state == DMR_IDLE && both_low) |=>
      (state == DMR_HOLD) && (cnt == '0)
  ) else $error("hold count did not start from zero");

  AST_ONE_PULSE: assert property (
    (state == DMR_SPENT && both_low) |=>
      sys_reset_n && (state == DMR_SPENT)
  ) else $error("second pulse during a continuous hold");

  AST_FALL_REARMS: assert property (
    (state == DMR_PULSE && any_fall && cnt != PULSE_LAST) |=> rearm
  ) else $error("edge during pulse not remembered");

  AST_REST_HIGH: assert property (
    !sys_reset_n |-> (state == DMR_PULSE) &&
      (pulse_len < CNT_W'(PULSE_CYC))
  ) else $error("reset output low outside a pulse");

  AST_PULSE_ENDS_SPENT: assert property (
    (state == DMR_PULSE && cnt == PULSE_LAST && both_low && !rearm &&
      !any_fall) |=> (state == DMR_SPENT) && sys_reset_n
  ) else $error("pulse under a steady hold did not end spent");

  AST_REARM_RESTARTS: assert property (
    (state == DMR_PULSE && cnt == PULSE_LAST &&
      (rearm || any_fall || !both_low)) |=> (state == DMR_IDLE) && sys_reset_n
  ) else $error("pulse after an edge did not return to idle");

endmodule

/* File: tb/dmr_pins.sv */
`timescale 1ns/100ps

// ***************************************************************
// switches at the two manual reset pins
// ***************************************************************
module dmr_pins (
  input  wire logic [1:0] press,
  input  wire logic       float2,
  output logic            first_n,
  output logic            second_n
);
  // first pin is always held at a defined level
  assign first_n  = ~press[0];
  // an open second pin reads high through its pull-up
  assign second_n = float2 ? 1'h1 : ~press[1];
endmodule

/* File: tb/dmr_timer_bench.sv */
`timescale 1ns/100ps

// ***************************************************************
// bench for the dual manual reset timer
// ***************************************************************
module dmr_timer_bench;
  import dmr_pkg::*;
  localparam int HOLD  = 20;
  localparam int PULSE = 10;
  localparam int PULSE_LONG = 30;
  logic       clk    = 1'h0;
  logic       rst    = 1'h1;
  logic [1:0] press  = 2'h0;
  logic       float2 = 1'h0;
  logic       first_n;
  logic       second_n;
  logic       sys_reset_n;
  logic       long_reset_n;
  int         cyc        = 0;
  int         n_errors   = 0;
  int         num_checks = 0;
  int         notes[$];

`define CHK(nm, ex, got) \
  begin num_checks++; if ((got) !== (ex)) begin \
    $display("Error %s expected %0h got %0h", nm, ex, got); \
    n_errors++; end end

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  dmr_pins pins (
    .press    (press),
    .float2   (float2),
    .first_n  (first_n),
    .second_n (second_n)
  );

  dmr_timer #(
    .LONG_VARIANT    (1'b0),
    .HOLD_CYC        (HOLD),
    .PULSE_SHORT_LEN (PULSE),
    .PULSE_LONG_LEN  (PULSE_LONG)
  ) DUT (
    .clk                         (clk),
    .rst                         (rst),
    .first_manual_reset_input_n  (first_n),
    .second_manual_reset_input_n (second_n),
    .sys_reset_n                 (sys_reset_n)
  );

  // long variant on the same pins; only its width and rest level are judged, since
  // pin edges during its longer pulse shift when it may fire again
  dmr_timer #(
    .LONG_VARIANT    (1'b1),
    .HOLD_CYC        (HOLD),
    .PULSE_SHORT_LEN (PULSE),
    .PULSE_LONG_LEN  (PULSE_LONG)
  ) DUT_LONG (
    .clk                         (clk),
    .rst                         (rst),
    .first_manual_reset_input_n  (first_n),
    .second_manual_reset_input_n (second_n),
    .sys_reset_n                 (long_reset_n)
  );

  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // set the switches, then let n edges pass
  task automatic hold(input logic [1:0] p, input int n);
    press <= p;
    repeat (n) @(posedge clk);
  endtask

  // cyc still shows the edge before: one more, two sync edges, one
  // state edge, then the full hold
  task automatic expect_pulse();
    notes.push_back(cyc + 4 + HOLD);
  endtask

  // ***************************************************************
  // stimulus
  // ***************************************************************
  initial begin : main
    int g;
    void'($urandom(13));
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    hold(2'h0, 5);
    hold(2'h1, 7);
    expect_pulse();
    hold(2'h3, 4 * HOLD);
    // fresh fall while spent
    hold(2'h1, 3);
    expect_pulse();
    hold(2'h3, 2 * HOLD + PULSE);
    // early release clears the count
    hold(2'h0, 5);
    hold(2'h3, HOLD - 2);
    hold(2'h2, 3);
    expect_pulse();
    hold(2'h3, 2 * HOLD + PULSE);
    // open second pin never counts as pressed
    float2 <= 1'h1;
    hold(2'h3, 3 * HOLD);
    float2 <= 1'h0;
    expect_pulse();
    hold(2'h3, 2 * HOLD + PULSE);
    // fall during a pulse: full width, then a fresh hold from its end
    hold(2'h0, 5);
    expect_pulse();
    notes.push_back(notes[$] + PULSE + 1 + HOLD);
    hold(2'h3, HOLD + 5);
    hold(2'h1, 2);
    hold(2'h3, 2 * HOLD + PULSE);
    for (int i = 0; i < 6; i++) begin
      g = $urandom_range(1, 6);
      hold(2'h0, 5);
      hold(2'($urandom_range(1, 2)), g);
      expect_pulse();
      hold(2'h3, HOLD + PULSE + 8);
    end
    hold(2'h0, 2 * HOLD);
    `CHK("pending_pulses", 0, notes.size())
    report_and_stop();
  end

  // ***************************************************************
  // output watcher: each pulse takes the oldest note
  // ***************************************************************
  initial begin : watch
    int t0;
    int w;
    int e;
    forever begin
      @(posedge clk);
      #1;
      if (sys_reset_n === 1'h0) begin
        t0 = cyc;
        w  = 0;
        // bounded so a stuck output cannot hang the run
        while (sys_reset_n === 1'h0 && w < 1000) begin
          @(posedge clk);
          #1;
          w++;
        end
        if (w >= 1000) begin
          n_errors++;
          report_and_stop();
        end else if (notes.size() == 0) begin
          `CHK("unexpected_pulse", 1'h0, 1'h1)
        end else begin
          e = notes.pop_front();
          `CHK("fall_edge", e, t0)
          `CHK("pulse_width", PULSE, w)
        end
      end else begin
        `CHK("rest_level", 1'h1, sys_reset_n)
      end
    end
  end

  // ***************************************************************
  // long variant watcher: every pulse keeps its full width
  // ***************************************************************
  initial begin : watch_long
    int wl;
    forever begin
      @(posedge clk);
      #1;
      if (long_reset_n === 1'h0) begin
        wl = 0;
        while (long_reset_n === 1'h0 && wl < 1000) begin
          @(posedge clk);
          #1;
          wl++;
        end
        if (wl >= 1000) begin
          n_errors++;
          report_and_stop();
        end else begin
          `CHK("long_pulse_width", PULSE_LONG, wl)
        end
      end else begin
        `CHK("long_rest_level", 1'h1, long_reset_n)
      end
    end
  end
endmodule
